// ===== rtl/status_record_defs.svh
// Offsets, field positions and reset values of the status record block
`ifndef STATUS_RECORD_DEFS_SVH
`define STATUS_RECORD_DEFS_SVH

// Record size and byte offsets
`define REC_BYTES 152
`define REC_LAST_IDX 8'h97
`define OFS_SAMPLE 0
`define OFS_INPUT 2
`define OFS_OUTPUT 12
`define OFS_ERROR 22
`define OFS_GSTAT 23
`define OFS_S_SEGS 24
`define OFS_S_STAT 26
`define OFS_S_DIST 28
`define OFS_T_SEGS 32
`define OFS_T_STAT 34
`define OFS_T_DIST 36
`define OFS_AXIS 40
`define IO_BYTES 10

// Offsets inside one axis block
`define AX_LEN 28
`define AX_STATUS 0
`define AX_SWITCHES 2
`define AX_STOPCODE 3
`define AX_REFPOS 4
`define AX_MOTPOS 8
`define AX_POSERR 12
`define AX_AUXPOS 16
`define AX_VEL 20
`define AX_TORQUE 24
`define AX_ANALOG 26

// General status byte bits
`define GST_RUN 7
`define GST_WAIT 2
`define GST_TRACE 1
`define GST_ECHO 0

// Axis switch byte bits
`define SWB_LATCHED 7
`define SWB_LATCH_IN 6
`define SWB_FWD 3
`define SWB_REV 2
`define SWB_HOME 1
`define SWB_STEPPER 0

// Plane status word bits
`define PLN_MOVE 15
`define PLN_SLEW 5
`define PLN_STOP 4
`define PLN_DECEL 3

// Velocity scale and torque limits
`define VEL_SHIFT 6
`define TORQUE_MAX 16'h7FFF
`define TORQUE_MIN 16'h8001
`define TORQUE_BAD 16'h8000

// APB register map
`define REG_CTRL 12'h000
`define REG_STATE 12'h004
`define REG_COUNT 12'h008
`define CTRL_RESET 32'h0000_0000
`define CTRL_EN 0
`define CTRL_FREEZE 1
`define CTRL_RATE_LSB 4
`define RATE_W 4
`define ST_BUSY 0
`define ST_FROZEN 1

`endif

// ===== rtl/status_record_pkg.sv
// Types shared by the status record block
package status_record_pkg;
    typedef enum logic [0:0] {
        IDLE_STATE = 1'b0,
        SEND_STATE = 1'b1
    } stream_state_t;
    typedef logic [7:0] byte_t;
endpackage

// ===== rtl/axis_block_packer.sv
// Packs one 28-byte axis block of the status record
`timescale 1ns/10ps
`include "status_record_defs.svh"

module axis_block_packer (
    input wire logic [15:0] status_word,
    input wire logic latched,
    input wire logic latch_in,
    input wire logic fwd_limit,
    input wire logic rev_limit,
    input wire logic home_in,
    input wire logic stepper_jumper,
    input wire logic [7:0] stop_code,
    input wire logic [31:0] ref_pos,
    input wire logic [31:0] motor_pos,
    input wire logic [31:0] pos_err,
    input wire logic [31:0] aux_pos,
    input wire logic [31:0] vel_query,
    input wire logic [15:0] torque,
    input wire logic [15:0] analog_in,
    output logic [`AX_LEN*8-1:0] blk
);
    logic [7:0] switches;
    logic [15:0] torque_lim;

    always_comb begin
        switches = 8'h00;
        switches[`SWB_LATCHED] = latched;
        switches[`SWB_LATCH_IN] = latch_in;
        switches[`SWB_FWD] = fwd_limit;
        switches[`SWB_REV] = rev_limit;
        switches[`SWB_HOME] = home_in;
        switches[`SWB_STEPPER] = stepper_jumper;
    end

    // Full scale is symmetric; the one code outside it is pulled in
    assign torque_lim = (torque == `TORQUE_BAD) ? `TORQUE_MIN : torque;

    always_comb begin
        blk = '0;
        blk[`AX_STATUS*8 +: 16] = status_word;
        blk[`AX_SWITCHES*8 +: 8] = switches;
        blk[`AX_STOPCODE*8 +: 8] = stop_code;
        blk[`AX_REFPOS*8 +: 32] = ref_pos;
        blk[`AX_MOTPOS*8 +: 32] = motor_pos;
        blk[`AX_POSERR*8 +: 32] = pos_err;
        blk[`AX_AUXPOS*8 +: 32] = aux_pos;
        blk[`AX_VEL*8 +: 32] = vel_query << `VEL_SHIFT;
        blk[`AX_TORQUE*8 +: 16] = torque_lim;
        blk[`AX_ANALOG*8 +: 16] = analog_in;
    end
endmodule

// ===== rtl/status_record_assembler.sv
// Status record assembler: snapshot, byte stream and APB control
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "status_record_defs.svh"

module status_record_assembler (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SAMPLE_TICK,
    input wire logic [15:0] SAMPLE_COUNT,
    input wire logic [79:0] GEN_INPUTS,
    input wire logic [79:0] GEN_OUTPUTS,
    input wire logic [7:0] ERROR_CODE,
    input wire logic PROG_RUNNING,
    input wire logic WAIT_INPUT,
    input wire logic TRACE_ON,
    input wire logic ECHO_ON,
    input wire logic [31:0] PLANE_SEGS,
    input wire logic [1:0] PLANE_MOVE,
    input wire logic [1:0] PLANE_SLEW,
    input wire logic [1:0] PLANE_STOP,
    input wire logic [1:0] PLANE_DECEL,
    input wire logic [63:0] PLANE_DIST,
    input wire logic [63:0] AXIS_STATUS,
    input wire logic [3:0] AXIS_LATCHED,
    input wire logic [3:0] AXIS_LATCH_IN,
    input wire logic [3:0] AXIS_FWD_LIMIT,
    input wire logic [3:0] AXIS_REV_LIMIT,
    input wire logic [3:0] AXIS_HOME,
    input wire logic [3:0] AXIS_STEPPER,
    input wire logic [31:0] AXIS_STOPCODE,
    input wire logic [127:0] AXIS_REFPOS,
    input wire logic [127:0] AXIS_MOTPOS,
    input wire logic [127:0] AXIS_POSERR,
    input wire logic [127:0] AXIS_AUXPOS,
    input wire logic [127:0] AXIS_VEL_QUERY,
    input wire logic [63:0] AXIS_TORQUE,
    input wire logic [63:0] AXIS_ANALOG,
    output status_record_pkg::byte_t BYTE_DATA,
    output logic BYTE_VALID,
    output logic BYTE_LAST,
    input wire logic BYTE_READY,
    output logic BUSY
);
    import status_record_pkg::*;

    localparam int REC_W = `REC_BYTES * 8;
    localparam int AXES = 4;

    logic [REC_W-1:0] rec_next;
    logic [REC_W-1:0] snap_reg;
    logic [`AX_LEN*8-1:0] axis_blk [AXES];
    logic [15:0] plane_word [2];
    logic [7:0] gstat;
    stream_state_t state_reg;
    logic [7:0] idx_reg;
    logic [7:0] idx_next;
    logic [31:0] ctrl_reg;
    logic [15:0] rate_cnt_reg;
    logic [15:0] period_m1;
    logic [15:0] records_reg;
    logic period_hit;
    logic start;
    logic accept;
    logic apb_done;

    // One packer per axis
    genvar g;
    generate
        for (g = 0; g < AXES; g = g + 1) begin : gen_axis
            axis_block_packer u_pack (
                .status_word(AXIS_STATUS[g*16 +: 16]),
                .latched(AXIS_LATCHED[g]),
                .latch_in(AXIS_LATCH_IN[g]),
                .fwd_limit(AXIS_FWD_LIMIT[g]),
                .rev_limit(AXIS_REV_LIMIT[g]),
                .home_in(AXIS_HOME[g]),
                .stepper_jumper(AXIS_STEPPER[g]),
                .stop_code(AXIS_STOPCODE[g*8 +: 8]),
                .ref_pos(AXIS_REFPOS[g*32 +: 32]),
                .motor_pos(AXIS_MOTPOS[g*32 +: 32]),
                .pos_err(AXIS_POSERR[g*32 +: 32]),
                .aux_pos(AXIS_AUXPOS[g*32 +: 32]),
                .vel_query(AXIS_VEL_QUERY[g*32 +: 32]),
                .torque(AXIS_TORQUE[g*16 +: 16]),
                .analog_in(AXIS_ANALOG[g*16 +: 16]),
                .blk(axis_blk[g])
            );
        end
    endgenerate

    // General status byte
    always_comb begin
        gstat = 8'h00;
        gstat[`GST_RUN] = PROG_RUNNING;
        gstat[`GST_WAIT] = WAIT_INPUT;
        gstat[`GST_TRACE] = TRACE_ON;
        gstat[`GST_ECHO] = ECHO_ON;
    end

    // Plane status words, unused bits zero
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            plane_word[p] = 16'h0000;
            plane_word[p][`PLN_MOVE] = PLANE_MOVE[p];
            plane_word[p][`PLN_SLEW] = PLANE_SLEW[p];
            plane_word[p][`PLN_STOP] = PLANE_STOP[p];
            plane_word[p][`PLN_DECEL] = PLANE_DECEL[p];
        end
    end

    // Record layout, low byte first
    always_comb begin
        rec_next = '0;
        rec_next[`OFS_SAMPLE*8 +: 16] = SAMPLE_COUNT;
        rec_next[`OFS_INPUT*8 +: `IO_BYTES*8] = GEN_INPUTS;
        rec_next[`OFS_OUTPUT*8 +: `IO_BYTES*8] = GEN_OUTPUTS;
        rec_next[`OFS_ERROR*8 +: 8] = ERROR_CODE;
        rec_next[`OFS_GSTAT*8 +: 8] = gstat;
        rec_next[`OFS_S_SEGS*8 +: 16] = PLANE_SEGS[15:0];
        rec_next[`OFS_S_STAT*8 +: 16] = plane_word[0];
        rec_next[`OFS_S_DIST*8 +: 32] = PLANE_DIST[31:0];
        rec_next[`OFS_T_SEGS*8 +: 16] = PLANE_SEGS[31:16];
        rec_next[`OFS_T_STAT*8 +: 16] = plane_word[1];
        rec_next[`OFS_T_DIST*8 +: 32] = PLANE_DIST[63:32];
        for (int a = 0; a < AXES; a++) begin
            rec_next[(`OFS_AXIS + a*`AX_LEN)*8 +: `AX_LEN*8] = axis_blk[a];
        end
    end

    // Update rate: one record every 2^n sample ticks
    assign period_m1 = 16'((32'h0000_0001 <<
        ctrl_reg[`CTRL_RATE_LSB +: `RATE_W]) - 32'h0000_0001);
    assign period_hit = SAMPLE_TICK && (rate_cnt_reg >= period_m1);
    assign start = period_hit && ctrl_reg[`CTRL_EN] &&
        !ctrl_reg[`CTRL_FREEZE] && (state_reg == IDLE_STATE);
    assign accept = (state_reg == SEND_STATE) && BYTE_VALID && BYTE_READY;
    assign idx_next = idx_reg + 8'h01;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rate_cnt_reg <= 16'h0000;
        end else if (SAMPLE_TICK) begin
            rate_cnt_reg <= period_hit ? 16'h0000 : rate_cnt_reg + 16'h0001;
        end
    end

    // Snapshot and byte stream
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            state_reg <= IDLE_STATE;
            snap_reg <= '0;
            idx_reg <= 8'h00;
            BYTE_DATA <= 8'h00;
            BYTE_VALID <= 1'b0;
            BYTE_LAST <= 1'b0;
        end else begin
            unique case (state_reg)
                IDLE_STATE: begin
                    if (start) begin
                        state_reg <= SEND_STATE;
                        snap_reg <= rec_next;
                        idx_reg <= 8'h00;
                        BYTE_DATA <= rec_next[7:0];
                        BYTE_VALID <= 1'b1;
                        BYTE_LAST <= 1'b0;
                    end
                end
                SEND_STATE: begin
                    if (accept && BYTE_LAST) begin
                        state_reg <= IDLE_STATE;
                        BYTE_VALID <= 1'b0;
                        BYTE_LAST <= 1'b0;
                    end else if (accept) begin
                        idx_reg <= idx_next;
                        BYTE_DATA <= snap_reg[{idx_next, 3'h0} +: 8];
                        BYTE_LAST <= (idx_next == `REC_LAST_IDX);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            BUSY <= 1'b0;
            records_reg <= 16'h0000;
        end else begin
            BUSY <= start || (state_reg == SEND_STATE &&
                !(accept && BYTE_LAST));
            if (accept && BYTE_LAST) begin
                records_reg <= records_reg + 16'h0001;
            end
        end
    end

    // APB slave, one wait state
    assign apb_done = PSEL && PENABLE && PREADY;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (apb_done && PWRITE && PADDR == `REG_CTRL) begin
            ctrl_reg <= PWDATA;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && PENABLE && !PREADY;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
            if (PSEL && PENABLE && !PREADY) begin
                unique case (PADDR)
                    `REG_CTRL: PRDATA <= PWRITE ? 32'h0000_0000 : ctrl_reg;
                    `REG_STATE: begin
                        if (!PWRITE) begin
                            PRDATA[`ST_BUSY] <= BUSY;
                            PRDATA[`ST_FROZEN] <= ctrl_reg[`CTRL_FREEZE];
                        end
                    end
                    `REG_COUNT: begin
                        if (!PWRITE) begin
                            PRDATA[15:0] <= records_reg;
                        end
                    end
                    default: PSLVERR <= 1'b1;
                endcase
            end
        end
    end

    // Checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    a_snap_whole: assert property (start |=> snap_reg == $past(rec_next))
        else $error("snapshot differs from assembled record");
    a_sample_word: assert property (
        rec_next[`OFS_SAMPLE*8 +: 16] == SAMPLE_COUNT &&
        rec_next[`OFS_GSTAT*8 +: 8] == gstat)
        else $error("sample count or status misplaced");
    a_plane_first: assert property (
        rec_next[`OFS_S_DIST*8 +: 32] == PLANE_DIST[31:0] &&
        rec_next[`OFS_S_STAT*8 + `PLN_MOVE] == PLANE_MOVE[0])
        else $error("first plane misplaced");
    a_plane_second: assert property (
        rec_next[`OFS_T_SEGS*8 +: 16] == PLANE_SEGS[31:16] &&
        rec_next[`OFS_T_DIST*8 +: 32] == PLANE_DIST[63:32])
        else $error("second plane misplaced");
    a_axis_first: assert property (
        rec_next[`OFS_AXIS*8 +: 16] == AXIS_STATUS[15:0] &&
        rec_next[(`OFS_AXIS + `AX_ANALOG)*8 +: 16] == AXIS_ANALOG[15:0])
        else $error("first axis block misplaced");
    a_axis_second: assert property (
        rec_next[(`OFS_AXIS + `AX_LEN + `AX_ANALOG)*8 +: 16] ==
        AXIS_ANALOG[31:16])
        else $error("second axis block misplaced");
    a_axis_third: assert property (
        rec_next[(`OFS_AXIS + 2*`AX_LEN)*8 +: 16] == AXIS_STATUS[47:32])
        else $error("third axis block misplaced");
    a_axis_fourth: assert property (
        rec_next[(`OFS_AXIS + 3*`AX_LEN + `AX_ANALOG)*8 +: 16] ==
        AXIS_ANALOG[63:48])
        else $error("fourth axis block misplaced");
    a_vel_scale: assert property (
        rec_next[(`OFS_AXIS + `AX_VEL)*8 +: 32] ==
        {AXIS_VEL_QUERY[25:0], 6'h00})
        else $error("velocity not scaled by 64");
    a_torque_range: assert property (
        start |=> snap_reg[(`OFS_AXIS + `AX_TORQUE)*8 +: 16] != `TORQUE_BAD)
        else $error("torque outside symmetric range");
    a_plane_zeros: assert property (
        (rec_next[`OFS_S_STAT*8 +: 16] & 16'h7FC7) == 16'h0000)
        else $error("plane status unused bits set");
    a_last_index: assert property (
        BYTE_VALID && BYTE_LAST |-> idx_reg == `REC_LAST_IDX)
        else $error("record length is not 152 bytes");
    a_stall_hold: assert property (
        BYTE_VALID && !BYTE_READY |=> BYTE_VALID && $stable(BYTE_DATA))
        else $error("byte dropped under back-pressure");
    a_apb_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held more than one cycle");

    c_record_start: cover property (start);
    c_record_done: cover property (accept && BYTE_LAST);
    c_stalled_byte: cover property (BYTE_VALID && !BYTE_READY);
    c_bad_address: cover property (PREADY && PSLVERR);
endmodule

// ===== sim/record_sink.sv
// Host model that reads record bytes, with optional stalls
`timescale 1ns/10ps
module record_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] data,
    input wire logic valid,
    input wire logic last,
    input wire logic stall,
    output logic ready,
    output logic [7:0] rec [0:151],
    output int nrec,
    output int last_at
);
    int idx;
    // Ready toggles while stalling, else stays high
    always_ff @(posedge clk) begin
        if (rst) begin
            ready <= 1'b0;
        end else begin
            ready <= stall ? ~ready : 1'b1;
        end
    end
    // Byte capture; a last byte closes the record
    always_ff @(posedge clk) begin
        if (rst) begin
            idx <= 0;
            nrec <= 0;
            last_at <= 0;
        end else if (valid && ready) begin
            rec[idx] <= data;
            idx <= last ? 0 : idx + 1;
            if (last) begin
                last_at <= idx;
                nrec <= nrec + 1;
            end
        end
    end
endmodule

// ===== sim/status_record_assembler_test.sv
// Testbench of the status record assembler
`timescale 1ns/10ps
module status_record_assembler_test;
    import status_record_pkg::*;
    typedef struct {
        logic [15:0] tq_in;
        logic [15:0] tq_exp;
        logic [3:0] fl;
        logic stall;
    } row_t;
    row_t rows [4] = '{'{16'h8000, 16'h8001, 4'hF, 1'b0},
        '{16'h7FFF, 16'h7FFF, 4'h0, 1'b1},
        '{16'h0000, 16'h0000, 4'hA, 1'b0},
        '{16'h8001, 16'h8001, 4'h5, 1'b1}};
    logic MCLK = 1'b0, SRST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
    logic PWRITE = 1'b0, SAMPLE_TICK = 1'b0, stall = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rd;
    logic PREADY, PSLVERR, BYTE_VALID, BYTE_LAST, BYTE_READY, BUSY, err;
    byte_t BYTE_DATA;
    logic PROG_RUNNING, WAIT_INPUT, TRACE_ON, ECHO_ON;
    logic [15:0] SAMPLE_COUNT;
    logic [79:0] GEN_INPUTS, GEN_OUTPUTS;
    logic [7:0] ERROR_CODE;
    logic [31:0] PLANE_SEGS, AXIS_STOPCODE;
    logic [1:0] PLANE_MOVE, PLANE_SLEW, PLANE_STOP, PLANE_DECEL;
    logic [63:0] PLANE_DIST, AXIS_STATUS, AXIS_TORQUE, AXIS_ANALOG;
    logic [3:0] AXIS_LATCHED, AXIS_LATCH_IN, AXIS_FWD_LIMIT;
    logic [3:0] AXIS_REV_LIMIT, AXIS_HOME, AXIS_STEPPER;
    logic [127:0] AXIS_REFPOS, AXIS_MOTPOS, AXIS_POSERR, AXIS_AUXPOS;
    logic [127:0] AXIS_VEL_QUERY;
    logic [7:0] rec [0:151];
    logic [7:0] exp_rec [0:151];
    int nrec, last_at, n_mismatch = 0, total_checks = 0, cycles = 0;

    status_record_assembler u_status_record_assembler (.*);
    record_sink u_record_sink (.clk(MCLK), .rst(SRST), .data(BYTE_DATA),
        .valid(BYTE_VALID), .last(BYTE_LAST), .stall(stall),
        .ready(BYTE_READY), .rec(rec), .nrec(nrec), .last_at(last_at));

    initial begin
        forever #5 MCLK = ~MCLK;
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One APB transfer, held until PREADY is seen
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        @(posedge MCLK);
        while (PREADY !== 1'b1) begin
            @(posedge MCLK);
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task tick;
        @(posedge MCLK);
        SAMPLE_TICK <= 1'b1;
        @(posedge MCLK);
        SAMPLE_TICK <= 1'b0;
    endtask

    task wait_rec(input int want);
        int t;
        t = 0;
        while (nrec < want && t < 800) begin
            @(posedge MCLK);
            t++;
        end
        @(posedge MCLK);
        chk("records", want, nrec);
        chk("BUSY idle", 0, BUSY);
        chk("valid idle", 0, BYTE_VALID);
    endtask

    task set_inputs(input int r);
        int k;
        logic [3:0] f;
        f = rows[r].fl;
        SAMPLE_COUNT <= 16'hC3A5 ^ 16'(r);
        for (k = 0; k < 10; k++) begin
            GEN_INPUTS[8*k+:8] <= 8'(k * 17 + r);
            GEN_OUTPUTS[8*k+:8] <= 8'(255 - k * 13 - r);
        end
        ERROR_CODE <= 8'(8'h40 + r);
        {PROG_RUNNING, WAIT_INPUT, TRACE_ON, ECHO_ON} <= f;
        {PLANE_MOVE, PLANE_SLEW, PLANE_STOP, PLANE_DECEL} <= {f, ~f};
        PLANE_SEGS <= 32'hBEEF_0102 + 32'(r);
        PLANE_DIST <= {32'h8765_4321, 32'hFFFF_FFFE} ^ 64'(r);
        {AXIS_LATCHED, AXIS_LATCH_IN} <= {f, ~f};
        AXIS_FWD_LIMIT <= {f[1:0], f[3:2]};
        {AXIS_REV_LIMIT, AXIS_HOME} <= {f ^ 4'h6, f ^ 4'h9};
        AXIS_STEPPER <= ~f ^ 4'h3;
        for (k = 0; k < 4; k++) begin
            AXIS_STATUS[16*k+:16] <= 16'(16'h5A3C * (k + 1)) ^
                16'(r * 16'h0F0F);
            AXIS_STOPCODE[8*k+:8] <= 8'(k * 5 + r + 1);
            AXIS_REFPOS[32*k+:32] <= 32'h8000_0011 * (k + 1) + r;
            AXIS_MOTPOS[32*k+:32] <= 32'hFFFF_F000 - k - r;
            AXIS_POSERR[32*k+:32] <= 32'h0000_7FFF << k;
            AXIS_AUXPOS[32*k+:32] <= ~(32'h0102_0304 * (k + r + 1));
            AXIS_VEL_QUERY[32*k+:32] <= 32'hFC00_0001 + k + r;
            AXIS_TORQUE[16*k+:16] <= rows[r].tq_in;
            AXIS_ANALOG[16*k+:16] <= 16'h8000 | 16'(k * 7 + r);
        end
        stall <= rows[r].stall;
    endtask

    task put(input int o, input int n, input logic [31:0] v);
        int k;
        for (k = 0; k < n; k++) begin
            exp_rec[o+k] = v[8*k+:8];
        end
    endtask

    // Expected record, little endian fields
    task build_exp(input logic [15:0] tq);
        int k;
        int o;
        put(0, 2, SAMPLE_COUNT);
        for (k = 0; k < 10; k++) begin
            put(2 + k, 1, GEN_INPUTS[8*k+:8]);
            put(12 + k, 1, GEN_OUTPUTS[8*k+:8]);
        end
        put(22, 1, ERROR_CODE);
        put(23, 1, {PROG_RUNNING, 4'h0, WAIT_INPUT, TRACE_ON, ECHO_ON});
        for (k = 0; k < 2; k++) begin
            put(24 + 8 * k, 2, PLANE_SEGS[16*k+:16]);
            put(26 + 8 * k, 2, {PLANE_MOVE[k], 9'h000, PLANE_SLEW[k],
                PLANE_STOP[k], PLANE_DECEL[k], 3'h0});
            put(28 + 8 * k, 4, PLANE_DIST[32*k+:32]);
        end
        for (k = 0; k < 4; k++) begin
            o = 40 + 28 * k;
            put(o, 2, AXIS_STATUS[16*k+:16]);
            put(o + 2, 1, {AXIS_LATCHED[k], AXIS_LATCH_IN[k], 2'h0,
                AXIS_FWD_LIMIT[k], AXIS_REV_LIMIT[k], AXIS_HOME[k],
                AXIS_STEPPER[k]});
            put(o + 3, 1, AXIS_STOPCODE[8*k+:8]);
            put(o + 4, 4, AXIS_REFPOS[32*k+:32]);
            put(o + 8, 4, AXIS_MOTPOS[32*k+:32]);
            put(o + 12, 4, AXIS_POSERR[32*k+:32]);
            put(o + 16, 4, AXIS_AUXPOS[32*k+:32]);
            put(o + 20, 4, {AXIS_VEL_QUERY[32*k+:26], 6'h00});
            put(o + 24, 2, tq);
            put(o + 26, 2, AXIS_ANALOG[16*k+:16]);
        end
    endtask

    // Compares a span of captured bytes
    task chk_span(input int lo, input int hi);
        for (int k = lo; k <= hi; k++) begin
            chk("byte", exp_rec[k], rec[k]);
        end
    endtask

    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test;
        end
    end

    initial begin
        int r;
        int k;
        set_inputs(0);
        repeat (3) @(posedge MCLK);
        SRST <= 1'b0;
        @(posedge MCLK);
        chk("BUSY reset", 0, BUSY);
        chk("valid reset", 0, BYTE_VALID);
        for (k = 0; k < 3; k++) begin
            apb(1'b0, 12'(4 * k), 32'h0000_0000);
            chk("register reset", 0, rd);
        end
        apb(1'b1, 12'h000, 32'h0000_0001);
        for (r = 0; r < 4; r++) begin
            set_inputs(r);
            tick;
            build_exp(rows[r].tq_exp);
            SAMPLE_COUNT <= ~SAMPLE_COUNT;
            @(posedge MCLK);
            chk("valid start", 1, BYTE_VALID);
            @(posedge MCLK);
            chk("BUSY", 1, BUSY);
            tick;
            wait_rec(r + 1);
            chk_span(0, 23);
            chk_span(24, 39);
            chk_span(40, 67);
            chk_span(68, 151);
            chk("last index", 151, last_at);
            apb(1'b0, 12'h008, 32'h0000_0000);
            chk("COUNT", r + 1, rd[15:0]);
        end
        apb(1'b1, 12'h000, 32'h0000_0003);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk("STATE frozen", 32'h0000_0002, rd);
        for (k = 0; k < 2; k++) begin
            apb(1'b1, 12'h000, k ? 32'h0000_0000 : 32'h0000_0003);
            tick;
            repeat (400) @(posedge MCLK);
            chk("records", 4, nrec);
        end
        apb(1'b1, 12'h000, 32'h0000_0011);
        for (k = 0; k < 4; k++) begin
            tick;
            repeat (400) @(posedge MCLK);
        end
        chk("records", 6, nrec);
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        chk("PSLVERR write", 1, err);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk("PSLVERR read", 1, err);
        chk("PRDATA", 0, rd);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk("CTRL", 32'h0000_0011, rd);
        chk("PSLVERR", 0, err);
        // Busy status, then reset in the middle of a record
        tick;
        tick;
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk("STATE busy", 32'h0000_0001, rd);
        SRST <= 1'b1;
        repeat (3) @(posedge MCLK);
        SRST <= 1'b0;
        @(posedge MCLK);
        chk("BUSY mid reset", 0, BUSY);
        chk("valid mid reset", 0, BYTE_VALID);
        chk("last mid reset", 0, BYTE_LAST);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk("CTRL mid reset", 0, rd);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("COUNT mid reset", 0, rd);
        finish_test;
    end
endmodule
